// ==== hw/sbhp_pkg.sv ====
// Package: shared bus host port constants and types
package sbhp_pkg;
  // ==========================================
  // Bus layout
  localparam int BUS_W = 16;
  localparam int ADDR_W = 8;
  localparam int LANE_W = 4;
  localparam int LANE_LSB = 12;
  localparam int ADDR_WIDE_LSB = 2;
  // ==========================================
  // Reset and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_HOLD_MS = 10;
  localparam int RESET_HOLD_CYC = RESET_HOLD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int STROBE_CYC = 2;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [3:0] LANE_RST = 4'h0;
  // Config memory address that triggers a config memory select
  localparam logic [7:0] CFG_MEM_ADDR = 8'hFC;
  typedef enum logic [2:0] {SBHP_IDLE, SBHP_SETUP, SBHP_STROBE, SBHP_HOLD, SBHP_RST} sbhp_state_t;
endpackage : sbhp_pkg

// ==== hw/sbhp_if.sv ====
// Interface: shared bus pins between host and device
`timescale 1ns/1ps
`default_nettype none
interface sbhp_if;
  logic host_select_low;
  logic read_strobe_low;
  logic write_strobe_low;
  logic cmd_type;
  logic hard_reset_low;
  logic [15:0] host_bus_out;
  logic [15:0] host_bus_oe;
  logic [15:0] dev_bus_out;
  logic [15:0] dev_bus_oe;
  logic [15:0] shared_bus_lines;
  logic config_memory_select;
  modport dev (input host_select_low, read_strobe_low, write_strobe_low, cmd_type,
               hard_reset_low, shared_bus_lines, output dev_bus_out, dev_bus_oe,
               config_memory_select);
  modport host (output host_select_low, read_strobe_low, write_strobe_low, cmd_type,
                hard_reset_low, host_bus_out, host_bus_oe, input shared_bus_lines,
                config_memory_select);
endinterface : sbhp_if
`default_nettype wire

// ==== hw/sbhp_device.sv ====
// Device end: decodes address, lane and data phases on the shared bus
//
// Functional notes
// - Command low: data phase, wide uses sixteen lines
// - Narrow data phase uses only low eight lines
// - Wide address phase: address bits 7:2 on 7:2
// - Wide lane enables on top lines; 11:8 ignored
// - Narrow address phase: full address on low lines
// - Accesses taken only while select is low
// - Device drives config memory select output
// - Low reset input puts device in reset
// - Reset held low at least ten milliseconds
// - Host uses separate low read/write strobes
// - Narrow mode: host grounds upper eight lines; this host drives them low only in address and write data phases
// - Lane enables active high; top line is lane 3
`timescale 1ns/1ps
`default_nettype none
module sbhp_device (
  // Clock and local reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Strap
  input wire logic WIDE_MODE,
  // Pins
  sbhp_if.dev PINS,
  // User side
  output logic [7:0] REG_ADDR,
  output logic [3:0] LANE_EN,
  output logic [15:0] WR_DATA,
  output logic WR_STB,
  output logic RD_STB,
  input wire logic [15:0] RD_DATA,
  output logic IN_RESET
);
  // ==========================================
  // Synchronisers: every pin is asynchronous to SYS_CLK
  logic [20:0] pins_raw;
  logic [20:0] pins_sync;
  assign pins_raw = {PINS.hard_reset_low, PINS.host_select_low, PINS.read_strobe_low,
                     PINS.write_strobe_low, PINS.cmd_type, PINS.shared_bus_lines};
  // Strobes and bus share one stage count, so a word and its strobe arrive together
  sbhp_sync2 #(
    .W(21)
  ) sbhp_sync2_i (
    .clk(SYS_CLK),
    .pin_in(pins_raw),
    .sync_out(pins_sync)
  );
  // ==========================================
  // Synchronised pins
  wire hard_rst_low_s = pins_sync[20];
  wire select_low_s = pins_sync[19];
  wire read_low_s = pins_sync[18];
  wire write_low_s = pins_sync[17];
  wire cmd_s = pins_sync[16];
  wire [15:0] bus_s = pins_sync[15:0];
  // ==========================================
  // Reset: local reset or the host's hard reset pin
  wire hrst = ~hard_rst_low_s | ~RESET_N;
  // ==========================================
  // Access qualify: no strobe counts while select is high
  wire sel = ~select_low_s;
  wire rd_act = sel & ~read_low_s;
  wire wr_act = sel & ~write_low_s;
  // ==========================================
  // Strobe edges: one access per falling strobe, however long it is held
  logic rd_prev_q;
  logic wr_prev_q;
  always_ff @(posedge SYS_CLK) begin
    rd_prev_q <= rd_act;
  end
  always_ff @(posedge SYS_CLK) begin
    wr_prev_q <= wr_act;
  end
  wire rd_fall = rd_act & ~rd_prev_q;
  wire wr_fall = wr_act & ~wr_prev_q;
  // ==========================================
  // Phase select: command high is an address phase
  wire addr_wr = wr_fall & cmd_s;
  wire data_wr = wr_fall & ~cmd_s;
  wire data_rd_start = rd_fall & ~cmd_s;
  wire data_rd = rd_act & ~cmd_s;
  // ==========================================
  // Width strap: taken only in reset so a live change cannot split an access
  logic wide_q;
  always_ff @(posedge SYS_CLK) begin
    if (hrst) begin
      wide_q <= WIDE_MODE;
    end
  end
  // ==========================================
  // Address decode
  wire [7:0] addr_wide = {bus_s[sbhp_pkg::ADDR_W-1:sbhp_pkg::ADDR_WIDE_LSB], 2'h0};
  wire [7:0] addr_narrow = bus_s[sbhp_pkg::ADDR_W-1:0];
  wire [7:0] addr_sel = wide_q ? addr_wide : addr_narrow;
  wire cfg_hit = addr_sel == sbhp_pkg::CFG_MEM_ADDR;
  // ==========================================
  // Lane decode: lines 11:8 are never looked at in an address phase
  wire [3:0] lanes_wide = bus_s[sbhp_pkg::LANE_LSB +: sbhp_pkg::LANE_W];
  // Narrow accesses carry no lane enables, so every lane counts as enabled
  wire [3:0] lanes_sel = wide_q ? lanes_wide : 4'hF;
  // ==========================================
  // Data decode: narrow mode keeps the upper byte at zero both ways
  wire [15:0] data_narrow = {8'h00, bus_s[7:0]};
  wire [15:0] data_sel = wide_q ? bus_s : data_narrow;
  wire [15:0] rd_narrow = {8'h00, RD_DATA[7:0]};
  wire [15:0] rd_sel = wide_q ? RD_DATA : rd_narrow;
  wire [15:0] lane_oe = wide_q ? 16'hFFFF : 16'h00FF;
  // ==========================================
  // Address phase registers
  logic [7:0] addr_q;
  logic [3:0] lane_q;
  logic cfg_q;
  always_ff @(posedge SYS_CLK) begin
    if (hrst) begin
      addr_q <= sbhp_pkg::ADDR_RST;
    end else if (addr_wr) begin
      addr_q <= addr_sel;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (hrst) begin
      lane_q <= sbhp_pkg::LANE_RST;
    end else if (addr_wr) begin
      lane_q <= lanes_sel;
    end
  end
  // Config memory select follows the last address phase, not each strobe
  always_ff @(posedge SYS_CLK) begin
    if (hrst) begin
      cfg_q <= 1'b0;
    end else if (addr_wr) begin
      cfg_q <= cfg_hit;
    end
  end
  // ==========================================
  // Data write registers
  logic [15:0] wdat_q;
  logic wstb_q;
  always_ff @(posedge SYS_CLK) begin
    if (hrst) begin
      wdat_q <= sbhp_pkg::DATA_RST;
    end else if (data_wr) begin
      wdat_q <= data_sel;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (hrst) begin
      wstb_q <= 1'b0;
    end else begin
      wstb_q <= data_wr;
    end
  end
  // ==========================================
  // Data read registers: the word is refreshed for as long as the strobe stands
  logic [15:0] rdat_q;
  logic rstb_q;
  logic rdrv_q;
  always_ff @(posedge SYS_CLK) begin
    if (hrst) begin
      rdat_q <= sbhp_pkg::DATA_RST;
    end else if (data_rd) begin
      rdat_q <= rd_sel;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (hrst) begin
      rstb_q <= 1'b0;
    end else begin
      rstb_q <= data_rd_start;
    end
  end
  // Release lags the strobe by the synchroniser depth plus this register, three cycles; the host's gap, HOLD plus one IDLE cycle, is two
  always_ff @(posedge SYS_CLK) begin
    if (hrst) begin
      rdrv_q <= 1'b0;
    end else begin
      rdrv_q <= data_rd;
    end
  end
  // ==========================================
  // Outputs
  assign PINS.dev_bus_out = rdat_q;
  assign PINS.dev_bus_oe = rdrv_q ? lane_oe : 16'h0000;
  assign PINS.config_memory_select = cfg_q;
  assign REG_ADDR = addr_q;
  assign LANE_EN = lane_q;
  assign WR_DATA = wdat_q;
  assign WR_STB = wstb_q;
  assign RD_STB = rstb_q;
  assign IN_RESET = hrst;
endmodule : sbhp_device
// ==========================================
// Two-flop synchroniser; only the second stage is read outside
module sbhp_sync2 #(
  parameter int W = 1
) (
  // Clock
  input wire logic clk,
  // Pin side
  input wire logic [W-1:0] pin_in,
  // Clock side
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  always_ff @(posedge clk) begin
    meta_q <= pin_in;
  end
  always_ff @(posedge clk) begin
    sync_q <= meta_q;
  end
  assign sync_out = sync_q;
endmodule : sbhp_sync2
`default_nettype wire

// ==== hw/sbhp_host.sv ====
// Host end: drives address and data phases with strobes
`timescale 1ns/1ps
`default_nettype none
module sbhp_host #(
  parameter int RESET_HOLD = sbhp_pkg::RESET_HOLD_CYC
) (
  // Clock, reset and strap
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic WIDE_MODE,
  // Pins
  sbhp_if.host PINS,
  // User request
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic [7:0] REQ_ADDR,
  input wire logic [3:0] REQ_LANES,
  input wire logic [15:0] REQ_WDATA,
  output logic [15:0] RSP_DATA,
  output logic RSP_VALID
);
  // ==========================================
  // Reset hold, long enough for the device
  logic [31:0] rcnt_q;
  wire rdone = rcnt_q >= 32'(RESET_HOLD);
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) rcnt_q <= '0;
    else if (!rdone) rcnt_q <= rcnt_q + 32'd1;
  end
  // ==========================================
  // Two-phase sequencer: address first, then data
  sbhp_pkg::sbhp_state_t st_q;
  logic ph_q, wr_q;
  logic [2:0] cnt_q;
  logic [15:0] bus_q, wd_q, rsp_q;
  logic rv_q;
  wire [15:0] abus = WIDE_MODE ? {REQ_LANES, 4'h0, REQ_ADDR[7:2], 2'b00}
                               : {8'h00, REQ_ADDR};
  wire [15:0] dbus = WIDE_MODE ? REQ_WDATA : {8'h00, REQ_WDATA[7:0]};
  logic [15:0] in1_q, in2_q;
  always_ff @(posedge SYS_CLK) begin
    in1_q <= PINS.shared_bus_lines;
    in2_q <= in1_q;
  end
  always_ff @(posedge SYS_CLK) begin
    rv_q <= 1'b0;
    if (!RESET_N || !rdone) begin
      st_q <= sbhp_pkg::SBHP_IDLE;
      ph_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 3'h0;
      bus_q <= sbhp_pkg::DATA_RST;
      wd_q <= sbhp_pkg::DATA_RST;
      rsp_q <= sbhp_pkg::DATA_RST;
    end else begin
      case (st_q)
        sbhp_pkg::SBHP_IDLE: if (REQ_VALID) begin
          bus_q <= abus;
          wd_q <= dbus;
          wr_q <= REQ_WRITE;
          ph_q <= 1'b1;
          st_q <= sbhp_pkg::SBHP_SETUP;
        end
        sbhp_pkg::SBHP_SETUP: begin
          cnt_q <= 3'h0;
          st_q <= sbhp_pkg::SBHP_STROBE;
        end
        sbhp_pkg::SBHP_STROBE: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'(sbhp_pkg::STROBE_CYC + 2)) st_q <= sbhp_pkg::SBHP_HOLD;
        end
        sbhp_pkg::SBHP_HOLD: begin
          if (ph_q) begin
            ph_q <= 1'b0;
            bus_q <= wd_q;
            st_q <= sbhp_pkg::SBHP_SETUP;
          end else begin
            rsp_q <= in2_q;
            rv_q <= 1'b1;
            st_q <= sbhp_pkg::SBHP_IDLE;
          end
        end
        default: st_q <= sbhp_pkg::SBHP_IDLE;
      endcase
    end
  end
  wire strobe = st_q == sbhp_pkg::SBHP_STROBE;
  wire busy = st_q != sbhp_pkg::SBHP_IDLE;
  // Command type stays put for the whole strobe
  assign PINS.cmd_type = ph_q;
  assign PINS.host_select_low = ~busy;
  assign PINS.write_strobe_low = ~(strobe & (ph_q | wr_q));
  assign PINS.read_strobe_low = ~(strobe & ~ph_q & ~wr_q);
  assign PINS.hard_reset_low = RESET_N & rdone;
  assign PINS.host_bus_out = bus_q;
  assign PINS.host_bus_oe = (busy && (ph_q || wr_q)) ? 16'hFFFF : 16'h0000;
  assign REQ_READY = ~busy & rdone;
  assign RSP_DATA = rsp_q;
  assign RSP_VALID = rv_q;
endmodule : sbhp_host
`default_nettype wire

// ==== dv/sbhp_asserts.sv ====
// Checker on the shared bus pins between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module sbhp_asserts (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Pins
  input wire logic host_select_low,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic cmd_type,
  input wire logic hard_reset_low,
  input wire logic [15:0] host_bus_oe,
  input wire logic [15:0] dev_bus_oe,
  input wire logic [15:0] shared_bus_lines,
  // Strap
  input wire logic wide_mode
);
  // ==========================================
  // Properties
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  wire logic idle_s = read_strobe_low & write_strobe_low;
  property p_undriven; host_select_low [*4] |-> dev_bus_oe == 16'h0000; endproperty
  a_undriven: assert property (p_undriven) else $error("bus driven while unselected");
  property p_sel_strobe; !idle_s |-> !host_select_low; endproperty
  a_sel_strobe: assert property (p_sel_strobe) else $error("strobe without select");
  property p_cmd_hold; !idle_s && !$past(idle_s) |-> $stable(cmd_type); endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command moved in strobe");
  property p_wr_len; $fell(write_strobe_low) |-> !write_strobe_low [*5]; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe short");
  property p_rd_len; $fell(read_strobe_low) |-> !read_strobe_low [*5]; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe short");
  // Sync flops delay the turn of the bus, so a small window is allowed
  property p_rd_drive; $fell(read_strobe_low) |-> ##[2:5] (dev_bus_oe != 16'h0000); endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read not answered");
  property p_no_fight; (host_bus_oe & dev_bus_oe) == 16'h0000; endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive");
  property p_rst_hold; $rose(RESET_N) |-> !hard_reset_low [*8]; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("hard reset too short");
  property p_narrow_upper; !wide_mode |-> shared_bus_lines[15:8] == 8'h00; endproperty
  a_narrow_upper: assert property (p_narrow_upper) else $error("upper lines set in narrow");
endmodule : sbhp_asserts
`default_nettype wire

// ==== dv/shared_bus_host_port_decode_tb_top.sv ====
// Testbench joining host and device ends over the shared bus
`timescale 1ns/1ps
`default_nettype none
module shared_bus_host_port_decode_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, wide = 1'b1, rq_v = 1'b0, rq_w = 1'b0;
  logic rq_rdy, rsp_v, in_rst, wr_stb, rd_stb;
  logic [3:0] rq_l = 4'h0, lane_en;
  logic [7:0] rq_a = 8'h00, reg_addr;
  logic [15:0] rq_d = 16'h0000, rd_data = 16'h0000, wr_data, rsp_data;
  int err_total = 0, check_count = 0;
  int wr_pulses = 0, rd_pulses = 0;
  always #5 clk = ~clk;
  // Strobe pulses last one cycle, so each spans exactly one falling edge
  always @(negedge clk) begin
    if (wr_stb === 1'b1) wr_pulses++;
    if (rd_stb === 1'b1) rd_pulses++;
  end
  // ==========================================
  // Ends, wire and checker
  sbhp_if pins ();
  // Undriven lines fall to the pull-down level
  assign pins.shared_bus_lines = (pins.host_bus_out & pins.host_bus_oe)
                               | (pins.dev_bus_out & pins.dev_bus_oe);
  sbhp_device sbhp_device_i (.SYS_CLK(clk), .RESET_N(rst_n), .WIDE_MODE(wide), .PINS(pins),
    .REG_ADDR(reg_addr), .LANE_EN(lane_en), .WR_DATA(wr_data), .WR_STB(wr_stb),
    .RD_STB(rd_stb),
    .RD_DATA(rd_data), .IN_RESET(in_rst));
  sbhp_host #(.RESET_HOLD(20)) sbhp_host_i (.SYS_CLK(clk), .RESET_N(rst_n), .WIDE_MODE(wide),
    .PINS(pins), .REQ_VALID(rq_v), .REQ_READY(rq_rdy), .REQ_WRITE(rq_w), .REQ_ADDR(rq_a),
    .REQ_LANES(rq_l), .REQ_WDATA(rq_d), .RSP_DATA(rsp_data), .RSP_VALID(rsp_v));
  sbhp_asserts sbhp_asserts_i (.SYS_CLK(clk), .RESET_N(rst_n),
    .host_select_low(pins.host_select_low), .read_strobe_low(pins.read_strobe_low),
    .write_strobe_low(pins.write_strobe_low), .cmd_type(pins.cmd_type),
    .hard_reset_low(pins.hard_reset_low), .host_bus_oe(pins.host_bus_oe),
    .dev_bus_oe(pins.dev_bus_oe), .wide_mode(wide),
    .shared_bus_lines(pins.shared_bus_lines));
  // ==========================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("Mismatches %0d, comparisons %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // Width is a strap, so it only changes under reset
  task automatic reset_ends(input logic w);
    @(negedge clk);
    rst_n = 1'b0;
    wide = w;
    repeat (8) @(negedge clk);
    chk(16'(in_rst), 16'h0001);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(16'(in_rst), 16'h0001);
  endtask : reset_ends
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] l,
                      input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    rq_v = 1'b1;
    rq_w = w;
    rq_a = a;
    rq_l = l;
    rq_d = d;
    while (rq_rdy !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      err_total++;
      $display("unexpected at %0t: request never taken", $time);
    end
    @(negedge clk);
    rq_v = 1'b0;
    n = 0;
    while (rsp_v !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) begin
      err_total++;
      $display("unexpected at %0t: no response", $time);
    end
  endtask : xfer
  // ==========================================
  // Tests
  initial begin
    #100000;
    err_total++;
    test_done();
  end
  initial begin
    reset_ends(1'b1);
    xfer(1'b1, 8'hFC, 4'hF, 16'h0000);
    chk(16'(pins.config_memory_select), 16'h0001);
    chk(16'(in_rst), 16'h0000);
    xfer(1'b1, 8'h37, 4'hA, 16'hBEEF);
    chk(16'(reg_addr), 16'h0034);
    chk(16'(lane_en), 16'h000A);
    chk(wr_data, 16'hBEEF);
    chk(16'(pins.config_memory_select), 16'h0000);
    rd_data = 16'h5AC3;
    xfer(1'b0, 8'h10, 4'h3, 16'h0000);
    chk(rsp_data, 16'h5AC3);
    reset_ends(1'b0);
    rd_data = 16'hFF3C;
    xfer(1'b1, 8'h37, 4'h0, 16'h12A5);
    chk(16'(reg_addr), 16'h0037);
    chk(16'(lane_en), 16'h000F);
    chk(wr_data, 16'h00A5);
    xfer(1'b0, 8'h37, 4'h0, 16'h0000);
    chk(rsp_data, 16'h003C);
    chk(16'(wr_pulses), 16'h0003);
    chk(16'(rd_pulses), 16'h0002);
    test_done();
  end
endmodule : shared_bus_host_port_decode_tb_top
`default_nettype wire
